// File: verilog/gpm_gpio_ports_with_pin_mux.sv
// GPIO ports with per-pin interrupts and the shared pin multiplexer
`timescale 1ns/1ps
module gpm_gpio_ports_with_pin_mux (
   input  wire logic                               CLK_IN,
   input  wire logic                               SYS_RST_IN,
   input  wire logic [gpm_pkg::PIN_CNT-1:0]        PORT_DIR_IN,
   input  wire logic [gpm_pkg::PIN_CNT-1:0]        PORT_DATA_IN,
   input  wire logic [gpm_pkg::PIN_CNT-1:0]        INT_EN_IN,
   input  wire gpm_pkg::gpm_trig_t [gpm_pkg::PIN_CNT-1:0] TRIG_SEL_IN,
   input  wire logic [gpm_pkg::PIN_CNT-1:0]        INT_CLR_IN,
   input  wire logic [7:0]                         ALT_SEL_B_IN,
   input  wire logic [7:0]                         ALT_SEL_C_IN,
   input  wire logic [7:0]                         ALT_SEL_D_IN,
   input  wire logic [7:0]                         ALT_SEL_E_IN,
   input  wire gpm_pkg::gpm_busb_drv_t             BUS_B_DRV_IN,
   input  wire gpm_pkg::gpm_spi_drv_t              SPI_DRV_IN,
   input  wire gpm_pkg::gpm_uart_drv_t             UART_DRV_IN,
   input  wire gpm_pkg::gpm_tmr_drv_t              TMR_DRV_IN,
   output gpm_pkg::gpm_spi_rcv_t                   SPI_RCV_OUT,
   output gpm_pkg::gpm_uart_rcv_t                  UART_RCV_OUT,
   output gpm_pkg::gpm_tmr_rcv_t                   TMR_RCV_OUT,
   input  wire logic [gpm_pkg::PIN_CNT-1:0]        PAD_IN,
   output logic [gpm_pkg::PIN_CNT-1:0]             PAD_OUT,
   output logic [gpm_pkg::PIN_CNT-1:0]             PAD_OE_OUT,
   output logic [gpm_pkg::PIN_CNT-1:0]             PIN_LEVEL_OUT,
   output logic [gpm_pkg::PIN_CNT-1:0]             INT_PEND_OUT,
   output logic                                    IRQ_OUT
);
   import gpm_pkg::*;

   //---------------------------------------------------------------------------
   // Input synchroniser and edge history
   //---------------------------------------------------------------------------
   logic [PIN_CNT-1:0] meta_q;
   logic [PIN_CNT-1:0] sync_q;
   logic [PIN_CNT-1:0] prev_q;

   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         meta_q <= PIN_RST;
         sync_q <= PIN_RST;
         prev_q <= PIN_RST;
      end else begin
         meta_q <= PAD_IN;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   assign PIN_LEVEL_OUT = sync_q;

   //---------------------------------------------------------------------------
   // Pin multiplexer
   //---------------------------------------------------------------------------
   logic [PIN_CNT-1:0] alt_on;
   logic [PIN_CNT-1:0] alt_out;
   logic [PIN_CNT-1:0] alt_oe;
   logic               spi_c_on;
   logic               mst;
   logic [7:0]         c_out;
   logic [7:0]         c_oe;
   logic [7:0]         d_out;
   logic [7:0]         d_oe;
   logic [7:0]         e_out;
   logic [7:0]         e_oe;

   // Port A has no alternate function
   assign alt_on = {ALT_SEL_E_IN & ALT_MASK_E, ALT_SEL_D_IN & ALT_MASK_D,
                    ALT_SEL_C_IN & ALT_MASK_C, ALT_SEL_B_IN & ALT_MASK_B,
                    8'h00};

   assign mst      = SPI_DRV_IN.master;
   assign spi_c_on = |(ALT_SEL_C_IN & ALT_MASK_C);

   assign c_out = {1'b0, SPI_DRV_IN.sck, SPI_DRV_IN.miso, SPI_DRV_IN.mosi,
                   SPI_DRV_IN.sel_n};
   // Select 0 always driven as master, 1..3 may float
   assign c_oe  = {1'b0, mst, ~mst, mst,
                   SPI_DRV_IN.sel_oe[3:1] & {3{mst}}, mst};

   assign d_out = {4'h0, UART_DRV_IN.rts_n, 2'b00, UART_DRV_IN.tx};
   assign d_oe  = 8'h09;

   assign e_out = {TMR_DRV_IN.line[0], TMR_DRV_IN.line[1], 1'b0,
                   TMR_DRV_IN.line[2], TMR_DRV_IN.line[3], 3'b000};
   assign e_oe  = {TMR_DRV_IN.line_oe[0], TMR_DRV_IN.line_oe[1], 1'b0,
                   TMR_DRV_IN.line_oe[2], TMR_DRV_IN.line_oe[3], 3'b000};

   assign alt_out = {e_out, d_out, c_out, BUS_B_DRV_IN.out, 8'h00};
   assign alt_oe  = {e_oe, d_oe, c_oe, BUS_B_DRV_IN.oe, 8'h00};

   //---------------------------------------------------------------------------
   // Pad drivers
   //---------------------------------------------------------------------------
   logic [PIN_CNT-1:0] out_d;
   logic [PIN_CNT-1:0] oe_d;
   logic [PIN_CNT-1:0] out_q;
   logic [PIN_CNT-1:0] oe_q;

   assign out_d = (alt_on & alt_out) | (~alt_on & PORT_DATA_IN);
   assign oe_d  = (alt_on & alt_oe) | (~alt_on & PORT_DIR_IN);

   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         out_q <= PIN_RST;
         oe_q  <= PIN_RST;
      end else begin
         out_q <= out_d;
         oe_q  <= oe_d;
      end
   end

   assign PAD_OUT    = out_q;
   assign PAD_OE_OUT = oe_q;

   //---------------------------------------------------------------------------
   // Peripheral receive side, idle values when not selected
   //---------------------------------------------------------------------------
   logic [7:0] c_in;
   logic [7:0] d_in;
   logic [7:0] e_in;
   logic [7:0] c_sel;
   logic [7:0] d_sel;
   logic [7:0] e_sel;

   assign c_in  = sync_q[PC_BASE +: 8];
   assign d_in  = sync_q[PD_BASE +: 8];
   assign e_in  = sync_q[PE_BASE +: 8];
   assign c_sel = alt_on[PC_BASE +: 8];
   assign d_sel = alt_on[PD_BASE +: 8];
   assign e_sel = alt_on[PE_BASE +: 8];

   assign SPI_RCV_OUT.slave_en_n = ~(c_sel[0] & ~mst & ~c_in[0]);
   assign SPI_RCV_OUT.mosi = c_sel[SPI_MOSI_BIT] & c_in[SPI_MOSI_BIT];
   assign SPI_RCV_OUT.miso = c_sel[SPI_MISO_BIT] & c_in[SPI_MISO_BIT];
   assign SPI_RCV_OUT.sck  = c_sel[SPI_SCK_BIT] & c_in[SPI_SCK_BIT];
   assign UART_RCV_OUT.rx    = ~d_sel[UART_RX_BIT] | d_in[UART_RX_BIT];
   assign UART_RCV_OUT.cts_n = ~d_sel[UART_CTS_BIT] | d_in[UART_CTS_BIT];
   assign TMR_RCV_OUT.line = {e_sel[T1B_BIT] & e_in[T1B_BIT],
                              e_sel[T1A_BIT] & e_in[T1A_BIT],
                              e_sel[T0B_BIT] & e_in[T0B_BIT],
                              e_sel[T0A_BIT] & e_in[T0A_BIT]};
   assign TMR_RCV_OUT.t1_clk = e_sel[T1CK_BIT] & e_in[T1CK_BIT];
   assign TMR_RCV_OUT.t2_clk = e_sel[T2CK_BIT] & e_in[T2CK_BIT];

   //---------------------------------------------------------------------------
   // Per-pin interrupt detection
   //---------------------------------------------------------------------------
   logic [PIN_CNT-1:0] hit;
   logic [PIN_CNT-1:0] is_edge;
   logic [PIN_CNT-1:0] pend_d;
   logic [PIN_CNT-1:0] pend_q;
   logic               irq_q;

   for (genvar i = 0; i < PIN_CNT; i++) begin : g_pin
      wire rise = sync_q[i] & ~prev_q[i];
      wire fall = ~sync_q[i] & prev_q[i];
      assign hit[i] = (TRIG_SEL_IN[i] == GPM_TRIG_RISE) ? rise :
                      (TRIG_SEL_IN[i] == GPM_TRIG_FALL) ? fall :
                      (TRIG_SEL_IN[i] == GPM_TRIG_BOTH) ? (rise | fall) :
                      (TRIG_SEL_IN[i] == GPM_TRIG_HIGH) ? sync_q[i] :
                      (TRIG_SEL_IN[i] == GPM_TRIG_LOW) ? ~sync_q[i] :
                      1'b0;
      assign is_edge[i] = (TRIG_SEL_IN[i] == GPM_TRIG_RISE) |
                          (TRIG_SEL_IN[i] == GPM_TRIG_FALL) |
                          (TRIG_SEL_IN[i] == GPM_TRIG_BOTH);
      // Edge: sticky, new edge beats clear; level: follows the pin
      assign pend_d[i] = INT_EN_IN[i] & (is_edge[i] ?
                         ((pend_q[i] & ~INT_CLR_IN[i]) | hit[i]) : hit[i]);
   end

   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         pend_q <= PIN_RST;
         irq_q  <= 1'b0;
      end else begin
         pend_q <= pend_d;
         irq_q  <= |pend_d;
      end
   end

   assign INT_PEND_OUT = pend_q;
   assign IRQ_OUT      = irq_q;

   //---------------------------------------------------------------------------
   // Assertions
   //---------------------------------------------------------------------------
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (SYS_RST_IN);

   logic [PIN_CNT-1:0] hold_v;
   logic [PIN_CNT-1:0] hit_en;
   assign hold_v = pend_q & ~INT_CLR_IN & INT_EN_IN & is_edge;
   assign hit_en = hit & INT_EN_IN;

   a_reset_inputs: assert property ($past(SYS_RST_IN) |-> PAD_OE_OUT == '0)
      else $error("pins not inputs after reset");
   a_port_dir: assert property (##1 (PAD_OE_OUT & ~$past(alt_on)) ==
                                ($past(PORT_DIR_IN) & ~$past(alt_on)))
      else $error("port direction not followed");
   a_port_data: assert property (##1 (PAD_OUT & ~$past(alt_on)) ==
                                 ($past(PORT_DATA_IN) & ~$past(alt_on)))
      else $error("port data not driven");
   a_port_a_plain: assert property (##1 PAD_OE_OUT[7:0] == $past(PORT_DIR_IN[7:0]))
      else $error("port A direction wrong");
   a_spi_master: assert property ((&ALT_SEL_C_IN[6:4] && mst) |=>
                                  PAD_OE_OUT[22] && PAD_OE_OUT[20] && !PAD_OE_OUT[21])
      else $error("SPI master directions wrong");
   a_spi_slave: assert property ((ALT_SEL_C_IN == 8'hff && !mst) |=>
                                 PAD_OE_OUT[23:16] == 8'h20)
      else $error("SPI slave directions wrong");
   a_uart_dirs: assert property (ALT_SEL_D_IN[3:0] == 4'hf |=>
                                 PAD_OE_OUT[27:24] == 4'h9)
      else $error("UART pin directions wrong");
   a_tmr_clk_in: assert property ((ALT_SEL_E_IN[5] && ALT_SEL_E_IN[2]) |=>
                                  !PAD_OE_OUT[37] && !PAD_OE_OUT[34])
      else $error("timer clock pins driven");
   a_edge_latch: assert property (##1 (pend_q & $past(hold_v)) == $past(hold_v))
      else $error("edge interrupt lost before clear");
   a_hit_pends: assert property (##1 (pend_q & $past(hit_en)) == $past(hit_en))
      else $error("trigger did not set pending");
   a_sync_two: assert property ($past(SYS_RST_IN, 2) == 1'b0 |->
                                PIN_LEVEL_OUT == $past(PAD_IN, 2))
      else $error("input sync depth wrong");
   a_irq_or: assert property (IRQ_OUT == |pend_q)
      else $error("interrupt output mismatch");

   c_spi_master: cover property (spi_c_on && mst ##1 PAD_OE_OUT[22]);
   c_edge_pend: cover property (|(pend_q & is_edge) ##1 |(INT_CLR_IN & pend_q));
   c_level_pend: cover property (|(pend_q & ~is_edge));
   c_uart_on: cover property (d_sel[UART_RX_BIT] && !UART_RCV_OUT.rx);
endmodule : gpm_gpio_ports_with_pin_mux

// File: verilog/gpm_pkg.sv
// Constants, types and carriers for the GPIO ports and pin multiplexer
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package gpm_pkg;
   localparam int PORT_CNT = 5;
   localparam int PORT_W   = 8;
   localparam int PIN_CNT  = PORT_CNT * PORT_W;
   localparam int PB_BASE  = 8;
   localparam int PC_BASE  = 16;
   localparam int PD_BASE  = 24;
   localparam int PE_BASE  = 32;
   localparam logic [7:0] ALT_MASK_B = 8'hff;
   localparam logic [7:0] ALT_MASK_C = 8'h7f;
   localparam logic [7:0] ALT_MASK_D = 8'h0f;
   localparam logic [7:0] ALT_MASK_E = 8'hfc;
   localparam int SPI_MOSI_BIT = 4;
   localparam int SPI_MISO_BIT = 5;
   localparam int SPI_SCK_BIT  = 6;
   localparam int UART_RX_BIT  = 1;
   localparam int UART_CTS_BIT = 2;
   localparam int T0A_BIT = 7;
   localparam int T0B_BIT = 6;
   localparam int T1CK_BIT = 5;
   localparam int T1A_BIT = 4;
   localparam int T1B_BIT = 3;
   localparam int T2CK_BIT = 2;
   localparam logic [PIN_CNT-1:0] PIN_RST = 40'h00_0000_0000;

   typedef enum logic [2:0] {GPM_TRIG_RISE, GPM_TRIG_FALL, GPM_TRIG_BOTH,
                             GPM_TRIG_HIGH, GPM_TRIG_LOW} gpm_trig_t;

   typedef struct packed {
      logic       master;
      logic [3:0] sel_n;
      logic [3:0] sel_oe;
      logic       mosi;
      logic       miso;
      logic       sck;
   } gpm_spi_drv_t;
   typedef struct packed {
      logic slave_en_n;
      logic mosi;
      logic miso;
      logic sck;
   } gpm_spi_rcv_t;
   typedef struct packed {
      logic tx;
      logic rts_n;
   } gpm_uart_drv_t;
   typedef struct packed {
      logic rx;
      logic cts_n;
   } gpm_uart_rcv_t;
   // Line order: timer0 A, timer0 B, timer1 A, timer1 B
   typedef struct packed {
      logic [3:0] line;
      logic [3:0] line_oe;
   } gpm_tmr_drv_t;
   typedef struct packed {
      logic [3:0] line;
      logic       t1_clk;
      logic       t2_clk;
   } gpm_tmr_rcv_t;
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
   } gpm_busb_drv_t;
endpackage : gpm_pkg

// File: testbench/gpm_pin_partner.sv
// External devices on the forty pins, with a moving level on undriven pins
`timescale 1ns/1ps
module gpm_pin_partner (
   input  wire logic [gpm_pkg::PIN_CNT-1:0] pad_out_in,
   input  wire logic [gpm_pkg::PIN_CNT-1:0] pad_oe_in,
   input  wire logic [gpm_pkg::PIN_CNT-1:0] ext_val_in,
   input  wire logic [gpm_pkg::PIN_CNT-1:0] ext_oe_in,
   input  wire logic                        clk_in,
   output logic      [gpm_pkg::PIN_CNT-1:0] pad_level_out
);
   logic tog_q = 1'b0;
   // No pull: a floating pin must not look like a steady level
   always @(posedge clk_in) begin
      tog_q <= ~tog_q;
   end
   assign pad_level_out = (pad_oe_in & pad_out_in)
                        | (~pad_oe_in & ext_oe_in & ext_val_in)
                        | (~pad_oe_in & ~ext_oe_in & {gpm_pkg::PIN_CNT{tog_q}});
endmodule : gpm_pin_partner

// File: testbench/testbench.sv
// Self-checking bench for the GPIO ports and pin multiplexer
`timescale 1ns/1ps
module testbench;
   import gpm_pkg::*;
   logic clk = 1'b0, rst = 1'b1;
   logic [39:0] dir = '0, data = '0, int_en = '0, int_clr = '0, ext_val = '0, ext_oe = '0;
   logic [39:0] pad_in, pad_out, pad_oe, pin_lvl, pend;
   logic [7:0] alt_b = '0, alt_c = '0, alt_d = '0, alt_e = '0;
   gpm_trig_t [39:0] trig;
   gpm_busb_drv_t busb = '0;
   gpm_spi_drv_t spi_drv = '0;
   gpm_uart_drv_t uart_drv = '0;
   gpm_tmr_drv_t tmr_drv = '0;
   gpm_spi_rcv_t spi_rcv;
   gpm_uart_rcv_t uart_rcv;
   gpm_tmr_rcv_t tmr_rcv;
   logic irq;
   int n_mismatch = 0, n_tests = 0;
   initial foreach (trig[i]) trig[i] = GPM_TRIG_RISE;
   always #2.5 clk = ~clk;
   gpm_gpio_ports_with_pin_mux uut (.CLK_IN(clk), .SYS_RST_IN(rst), .PORT_DIR_IN(dir), .PORT_DATA_IN(data),
      .INT_EN_IN(int_en), .TRIG_SEL_IN(trig), .INT_CLR_IN(int_clr), .ALT_SEL_B_IN(alt_b), .ALT_SEL_C_IN(alt_c),
      .ALT_SEL_D_IN(alt_d), .ALT_SEL_E_IN(alt_e), .BUS_B_DRV_IN(busb), .SPI_DRV_IN(spi_drv),
      .UART_DRV_IN(uart_drv), .TMR_DRV_IN(tmr_drv), .SPI_RCV_OUT(spi_rcv), .UART_RCV_OUT(uart_rcv),
      .TMR_RCV_OUT(tmr_rcv), .PAD_IN(pad_in), .PAD_OUT(pad_out), .PAD_OE_OUT(pad_oe),
      .PIN_LEVEL_OUT(pin_lvl), .INT_PEND_OUT(pend), .IRQ_OUT(irq));
   gpm_pin_partner partner (.pad_out_in(pad_out), .pad_oe_in(pad_oe), .ext_val_in(ext_val),
      .ext_oe_in(ext_oe), .clk_in(clk), .pad_level_out(pad_in));
   task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : wait_cyc
   task automatic test_done;
      $display("Checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : test_done
   task automatic t_output;
      @(posedge clk);
      dir <= '1;
      data <= 40'ha5_3c_0f_f0_96;
      wait_cyc(2);
      check("pad_oe all", pad_oe, '1);
      check("pad_out all", pad_out, 40'ha5_3c_0f_f0_96);
      @(posedge clk);
      dir <= 40'h80_0000_0001;
      wait_cyc(2);
      check("pad_oe single", pad_oe, 40'h80_0000_0001);
      @(posedge clk);
      dir <= '0;
   endtask : t_output
   task automatic t_input;
      @(posedge clk);
      ext_oe <= '1;
      ext_val <= 40'h12_34_56_78_9a;
      wait_cyc(3);
      check("pin level", pin_lvl, 40'h12_34_56_78_9a);
      check("pad_oe input", pad_oe, '0);
   endtask : t_input
   task automatic t_trig;
      logic [4:0] exp_a, exp_b, exp_c;
      exp_a = 5'b10000;
      exp_b = 5'b01101;
      exp_c = 5'b10110;
      for (int t = 0; t < 5; t++) begin
         @(posedge clk);
         int_en[0] <= 1'b0;
         trig[0] <= gpm_trig_t'(t[2:0]);
         ext_val[0] <= 1'b0;
         wait_cyc(4);
         @(posedge clk);
         int_en[0] <= 1'b1;
         wait_cyc(4);
         check("pend idle", pend, {39'h0, exp_a[t]});
         @(posedge clk);
         int_clr[0] <= 1'b1;
         @(posedge clk);
         int_clr[0] <= 1'b0;
         ext_val[0] <= 1'b1;
         wait_cyc(4);
         check("pend high", pend, {39'h0, exp_b[t]});
         check("irq high", irq, exp_b[t]);
         @(posedge clk);
         int_clr[0] <= 1'b1;
         @(posedge clk);
         int_clr[0] <= 1'b0;
         ext_val[0] <= 1'b0;
         wait_cyc(4);
         check("pend low", pend, {39'h0, exp_c[t]});
      end
      @(posedge clk);
      int_en[0] <= 1'b0;
   endtask : t_trig
   task automatic t_spi;
      @(posedge clk);
      alt_c <= 8'hff;
      ext_oe <= 40'h00_00_01_00_00;
      spi_drv <= '{master: 1'b1, sel_n: 4'b1110, sel_oe: 4'b0101, mosi: 1'b1, miso: 1'b0, sck: 1'b1};
      wait_cyc(2);
      check("spi master oe", pad_oe[23:16], 8'h55);
      check("spi master out", pad_out[23:16] & pad_oe[23:16], 8'h54);
      @(posedge clk);
      spi_drv <= '{master: 1'b0, sel_n: 4'b0000, sel_oe: 4'b1111, mosi: 1'b0, miso: 1'b1, sck: 1'b0};
      wait_cyc(3);
      check("spi slave oe", pad_oe[23:16], 8'h20);
      check("spi slave miso", pad_out[21], 1'b1);
      check("slave enable low", spi_rcv.slave_en_n, 1'b0);
      @(posedge clk);
      ext_val[16] <= 1'b1;
      wait_cyc(3);
      check("slave enable high", spi_rcv.slave_en_n, 1'b1);
   endtask : t_spi
   task automatic t_uart_tmr;
      @(posedge clk);
      alt_c <= 8'h00;
      alt_b <= 8'hff;
      alt_d <= 8'hff;
      alt_e <= 8'hff;
      busb <= '{out: 8'hc3, oe: 8'h0f};
      uart_drv <= '{tx: 1'b1, rts_n: 1'b0};
      tmr_drv <= '{line: 4'b0001, line_oe: 4'b0101};
      ext_oe <= 40'h6c_06_00_00_00;
      ext_val <= 40'h6c_00_00_00_00;
      wait_cyc(3);
      check("mux oe", pad_oe, 40'h90_09_00_0f_00);
      check("mux out", pad_out & pad_oe, 40'h80_01_00_03_00);
      check("uart rcv", uart_rcv, 2'b00);
      check("tmr rcv", tmr_rcv, 6'b101111);
      @(posedge clk);
      alt_d <= 8'h00;
      alt_e <= 8'h00;
      wait_cyc(2);
      check("port back", pad_oe, 40'h00_00_00_0f_00);
   endtask : t_uart_tmr
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      wait_cyc(1);
      check("reset oe", pad_oe, '0);
      check("reset pend", pend, '0);
      t_output();
      t_input();
      t_trig();
      t_spi();
      t_uart_tmr();
      test_done();
   end
   initial begin
      #20000;
      n_mismatch++;
      test_done();
   end
endmodule : testbench
